// *** lbpm_clkdiv.v ***
// Local bus clock divider with half-period high phase
`timescale 1ns/1ps
`include "lbpm_defines.vh"
module lbpm_clkdiv (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Configuration
    input wire [1:0] i_div_sel,
    // Outputs
    output wire o_local_bus_clock,
    output reg o_tick
);
    reg [3:0] cnt_r;
    reg [3:0] cnt_nxt;
    reg [3:0] top;

    // Terminal count from divide selection
    always @* begin
        case (i_div_sel)
            `LBPM_DIV_2: top = 4'h1;
            `LBPM_DIV_4: top = 4'h3;
            `LBPM_DIV_8: top = 4'h7;
            default: top = 4'hF;
        endcase
        cnt_nxt = (cnt_r >= top) ? `LBPM_RST_DIVCNT : cnt_r + 4'h1;
    end

    // Divider count and tick
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= `LBPM_RST_DIVCNT;
            o_tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            o_tick <= (cnt_nxt == 4'h0);
        end
    end

    // High phase is the low half of the tick cycle: half a period
    // Gating with the low phase avoids a glitch when the tick drops at a rising edge
    assign o_local_bus_clock = o_tick & ~i_clk;
endmodule

// *** lbpm_defines.vh ***
// Constants for the local bus pin mux and hold block
`ifndef LBPM_DEFINES_VH
`define LBPM_DEFINES_VH
// Peripheral configuration field codes
`define LBPM_CFG_ADDR16 3'h0
`define LBPM_CFG_GP8_A8 3'h2
`define LBPM_CFG_GP8_SSC 3'h3
`define LBPM_CFG_MUXAD 3'h4
// Field positions
`define LBPM_CFG_TOP 2
// Clock divide field codes (divide factor 2,4,8,16)
`define LBPM_DIV_2 2'h0
`define LBPM_DIV_4 2'h1
`define LBPM_DIV_8 2'h2
`define LBPM_DIV_16 2'h3
// Reset values
`define LBPM_RST_DIVCNT 4'h0
`endif

// *** lbpm_peripheral.sv ***
// Local bus peripheral model: word store with wait states
`timescale 1ns/1ps
module lbpm_peripheral (
    // Clock and strobes
    input wire clk,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    // Address, data and wait control
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire [3:0] waits,
    output wire [15:0] rdata,
    output wire wait_req
);
    reg [15:0] mem [0:15];
    reg [15:0] last_r = 16'h0000;
    reg [3:0] cnt_r = 4'h0;
    reg seen_r = 1'b0;
    wire strb = !cs_n && !(rd_n && wr_n);
    // Released bus shows the inverse of the last word, never a stale copy
    assign rdata = (!cs_n && !rd_n) ? mem[addr[3:0]] : ~last_r;
    // Wait asked from the first strobe cycle, for waits+1 cycles when waits is nonzero
    assign wait_req = strb && (seen_r ? cnt_r != 4'h0 : waits != 4'h0);
    // Store writes and count the wait span down
    always @(posedge clk) begin
        seen_r <= strb;
        cnt_r <= (strb && !seen_r) ? waits : cnt_r - {3'h0, cnt_r != 4'h0};
        if (strb && !wr_n) mem[addr[3:0]] <= wdata;
        if (strb && !rd_n) last_r <= rdata;
    end
endmodule

// *** lbpm_pinmux.v ***
// Address and data pin multiplexer for all configurations
`timescale 1ns/1ps
`include "lbpm_defines.vh"
module lbpm_pinmux (
    // Mode selection
    input wire i_split,
    input wire [2:0] i_cfg,
    // Sources
    input wire [31:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_addr_phase,
    input wire i_drive,
    input wire i_write,
    input wire [7:0] i_gp_out,
    input wire [7:0] i_gp_oe,
    input wire [6:0] i_ssc_out,
    input wire [6:0] i_ssc_oe,
    // Pins
    output reg [15:0] o_a,
    output reg [15:0] o_a_oe,
    output reg [15:0] o_d,
    output reg [15:0] o_d_oe
);
    // Pin routing per configuration
    always @* begin
        o_a = 16'h0000;
        o_a_oe = 16'h0000;
        o_d = i_wdata;
        o_d_oe = 16'h0000;
        if (i_split) begin
            o_a = {i_addr[15:2], 2'b00};
            o_a_oe = i_drive ? 16'hFFFC : 16'h0000;
            o_d = i_addr[31:16];
            o_d_oe = i_drive ? 16'hFFFF : 16'h0000;
        end else if (i_cfg == `LBPM_CFG_MUXAD) begin
            o_d = i_addr_phase ? i_addr[15:0] : i_wdata;
            o_d_oe = (i_drive & (i_addr_phase | i_write)) ? 16'hFFFF : 16'h0000;
        end else if (i_cfg[`LBPM_CFG_TOP] == 1'b0) begin
            o_d_oe = (i_drive & i_write) ? 16'hFFFF : 16'h0000;
            if (i_cfg == `LBPM_CFG_GP8_SSC) begin
                o_a = {i_gp_out, 1'b1, i_ssc_out};
                o_a_oe = {i_gp_oe, 1'b0, i_ssc_oe};
            end else if (i_cfg == `LBPM_CFG_GP8_A8) begin
                o_a = {i_gp_out, i_addr[7:0]};
                o_a_oe = {i_gp_oe, i_drive ? 8'hFF : 8'h00};
            end else begin
                o_a = i_addr[15:0];
                o_a_oe = i_drive ? 16'hFFFF : 16'h0000;
            end
        end
    end
endmodule

// *** lbpm_top.v ***
// Local bus interface pin mux, hold arbitration and bus cycle sequencer
// Overview of operation
// - Config 011: upper pins general port, lower pins serial control, one reserved
// - Config 010: upper pins general port, lower eight pins local address
// - Split strap high: host address bits 15 to 2 on address pins 15 to 2, low two pins undriven
// - Split mode: host address bits 31 to 16 on data pins
// - Top config bit zero: data pins form 16-bit local data bus
// - Config 100: data pins carry multiplexed address and data
// - Bus request driven low to ask for bus, high once regained
// - As arbitration master, hold status pin driven low confirms hold
// - With external arbiter, hold status high keeps device in hold
// - Read, write, upper byte strobes tri-stated unless device is master
// - Target ready input stretches current cycle with wait states
// - Address latch strobe tri-stated when unused, e.g. split mode
// - Peripheral select asserted during local bus accesses
// - Config 000: all sixteen address pins form local address bus
// - Local clock is divided system clock, high phase half a period
`timescale 1ns/1ps
`include "lbpm_defines.vh"
module lbpm_top (
    // Clock and reset
    input wire I_MCLK,
    input wire I_RST,
    // Configuration
    input wire I_SPLIT_BUS_STRAP,
    input wire [2:0] I_PERIPHERAL_CONFIG_FIELD,
    input wire [1:0] I_CLOCK_DIVIDE_FIELD,
    input wire I_ARBITER_MASTER_ENABLE,
    input wire I_READY_ACTIVE_HIGH,
    // Access request
    input wire I_REQ,
    input wire I_REQ_WRITE,
    input wire I_REQ_UPPER,
    input wire [31:0] I_REQ_ADDR,
    input wire [15:0] I_REQ_WDATA,
    output wire O_REQ_READY,
    output reg O_DONE,
    output reg [15:0] O_RDATA,
    // General port and serial control sources
    input wire [7:0] I_GP_OUT,
    input wire [7:0] I_GP_OE,
    input wire [6:0] I_SSC_OUT,
    input wire [6:0] I_SSC_OE,
    output wire [7:0] O_GP_IN,
    output wire [6:0] O_SSC_IN,
    // Address and data pins
    input wire [15:0] I_LA,
    output wire [15:0] O_LA,
    output wire [15:0] O_LA_OE,
    input wire [15:0] I_LD,
    output wire [15:0] O_LD,
    output wire [15:0] O_LD_OE,
    // Arbitration pins
    input wire I_HOLD_REQUEST_IN,
    output reg O_BUS_REQUEST_OUT,
    input wire I_HOLD_STATUS_PIN,
    output wire O_HOLD_STATUS_PIN,
    output wire O_HOLD_STATUS_PIN_OE,
    output wire O_IN_HOLD,
    // Strobes
    input wire I_WAIT_READY_IN,
    output wire O_PERIPHERAL_SELECT_OUT_N,
    output wire O_ADDR_LATCH_STROBE,
    output wire O_ADDR_LATCH_STROBE_OE,
    output wire O_READ_STROBE_N,
    output wire O_READ_STROBE_N_OE,
    output wire O_WRITE_STROBE_N,
    output wire O_WRITE_STROBE_N_OE,
    output wire O_UPPER_BYTE_ENABLE_N,
    output wire O_UPPER_BYTE_ENABLE_N_OE,
    output wire O_LOCAL_BUS_CLOCK
);
    // Bus cycle states, one-hot
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_STRB = 5'h04;
    localparam [4:0] ST_DONE = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg master_r;
    reg [31:0] addr_r;
    reg [15:0] wdata_r;
    reg write_r;
    reg upper_r;
    reg ale_r;
    reg rd_r;
    reg wr_r;
    reg cs_r;
    reg breq_wait_r;
    wire tick;
    wire hold_ask;
    wire wait_req;
    wire muxed;

    // Divided local clock; all bus steps advance on its tick
    lbpm_clkdiv u_clkdiv (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_div_sel(I_CLOCK_DIVIDE_FIELD),
        .o_local_bus_clock(O_LOCAL_BUS_CLOCK),
        .o_tick(tick)
    );

    // Hold asked by request low, or by external arbiter holding status high
    assign hold_ask = ~I_HOLD_REQUEST_IN | (~I_ARBITER_MASTER_ENABLE & I_HOLD_STATUS_PIN);
    // Ready polarity is configurable since targets differ
    assign wait_req = I_READY_ACTIVE_HIGH ? I_WAIT_READY_IN : ~I_WAIT_READY_IN;
    assign muxed = ~I_SPLIT_BUS_STRAP & (I_PERIPHERAL_CONFIG_FIELD == `LBPM_CFG_MUXAD);
    assign O_REQ_READY = (state_r == ST_IDLE) & tick & ~hold_ask;

    // Next state of the bus cycle sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (hold_ask & tick) begin
                    state_nxt = ST_HOLD;
                end else if (I_REQ & O_REQ_READY) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (tick) begin
                    state_nxt = ST_STRB;
                end
            end
            ST_STRB: begin
                if (tick & ~wait_req) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (tick) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (~hold_ask & tick) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Sequencer registers and strobes
    always @(posedge I_MCLK) begin
        if (I_RST) begin
            state_r <= ST_IDLE;
            master_r <= 1'b1;
            addr_r <= 32'h00000000;
            wdata_r <= 16'h0000;
            write_r <= 1'b0;
            upper_r <= 1'b0;
            ale_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cs_r <= 1'b0;
            O_DONE <= 1'b0;
            O_RDATA <= 16'h0000;
            O_BUS_REQUEST_OUT <= 1'b1;
            breq_wait_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            O_DONE <= 1'b0;
            master_r <= (state_nxt != ST_HOLD);
            if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
                addr_r <= I_REQ_ADDR;
                wdata_r <= I_REQ_WDATA;
                write_r <= I_REQ_WRITE;
                upper_r <= I_REQ_UPPER;
            end
            ale_r <= (state_nxt == ST_ADDR) & muxed & ~I_SPLIT_BUS_STRAP;
            cs_r <= (state_nxt == ST_ADDR) | (state_nxt == ST_STRB);
            rd_r <= (state_nxt == ST_STRB) & ~write_r;
            wr_r <= (state_nxt == ST_STRB) & write_r;
            if (state_r == ST_STRB && state_nxt == ST_DONE) begin
                O_RDATA <= I_LD;
                O_DONE <= 1'b1;
            end
            // Request the bus while held with work pending, release once regained
            if (state_r == ST_HOLD && I_REQ && !breq_wait_r) begin
                O_BUS_REQUEST_OUT <= 1'b0;
                breq_wait_r <= 1'b1;
            end else if (breq_wait_r && state_r != ST_HOLD) begin
                O_BUS_REQUEST_OUT <= 1'b1;
                breq_wait_r <= 1'b0;
            end
        end
    end

    // Address, data and shared pin routing
    lbpm_pinmux u_pinmux (
        .i_split(I_SPLIT_BUS_STRAP),
        .i_cfg(I_PERIPHERAL_CONFIG_FIELD),
        .i_addr(addr_r),
        .i_wdata(wdata_r),
        .i_addr_phase(state_r == ST_ADDR),
        .i_drive(master_r & (state_r != ST_IDLE)),
        .i_write(write_r),
        .i_gp_out(I_GP_OUT),
        .i_gp_oe(I_GP_OE),
        .i_ssc_out(I_SSC_OUT),
        .i_ssc_oe(I_SSC_OE),
        .o_a(O_LA),
        .o_a_oe(O_LA_OE),
        .o_d(O_LD),
        .o_d_oe(O_LD_OE)
    );
    assign O_GP_IN = I_LA[15:8];
    assign O_SSC_IN = I_LA[6:0];

    // Hold status driven low as master while in hold, else input only
    assign O_HOLD_STATUS_PIN = ~(state_r == ST_HOLD);
    assign O_HOLD_STATUS_PIN_OE = I_ARBITER_MASTER_ENABLE;
    assign O_IN_HOLD = ~master_r;

    // Strobes float unless master; latch strobe floats in split mode
    assign O_PERIPHERAL_SELECT_OUT_N = ~cs_r;
    assign O_ADDR_LATCH_STROBE = ale_r;
    assign O_ADDR_LATCH_STROBE_OE = master_r & muxed;
    assign O_READ_STROBE_N = ~rd_r;
    assign O_READ_STROBE_N_OE = master_r;
    assign O_WRITE_STROBE_N = ~wr_r;
    assign O_WRITE_STROBE_N_OE = master_r;
    assign O_UPPER_BYTE_ENABLE_N = ~upper_r;
    assign O_UPPER_BYTE_ENABLE_N_OE = master_r;
endmodule

// *** lbpm_top_monitor.sv ***
// Checker for pin mux, hold arbitration and strobe rules
`timescale 1ns/1ps
module lbpm_monitor (
    // Clock, reset and configuration
    input wire I_MCLK, input wire I_RST, input wire I_SPLIT_BUS_STRAP, input wire [2:0] I_PERIPHERAL_CONFIG_FIELD,
    input wire I_ARBITER_MASTER_ENABLE, input wire I_READY_ACTIVE_HIGH, input wire I_WAIT_READY_IN,
    // Pin sources and pins
    input wire [7:0] I_GP_OUT, input wire [7:0] I_GP_OE, input wire [6:0] I_SSC_OUT, input wire [6:0] I_SSC_OE,
    input wire [15:0] O_LA, input wire [15:0] O_LA_OE,
    // Handshake, arbitration and strobes
    input wire O_REQ_READY, input wire O_DONE, input wire O_IN_HOLD, input wire O_BUS_REQUEST_OUT,
    input wire I_HOLD_STATUS_PIN, input wire O_HOLD_STATUS_PIN, input wire O_HOLD_STATUS_PIN_OE,
    input wire O_PERIPHERAL_SELECT_OUT_N, input wire O_ADDR_LATCH_STROBE_OE, input wire O_READ_STROBE_N,
    input wire O_READ_STROBE_N_OE, input wire O_WRITE_STROBE_N_OE, input wire O_UPPER_BYTE_ENABLE_N_OE
);
    wire wait_act;
    wire rd_act;
    // Wait request seen in the polarity the design is set to
    assign wait_act = I_READY_ACTIVE_HIGH ? I_WAIT_READY_IN : !I_WAIT_READY_IN;
    assign rd_act = !O_READ_STROBE_N && O_READ_STROBE_N_OE;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // Strobes float while another master owns the bus
    a_strobe_tri_hold: assert property (
        O_IN_HOLD |-> !(O_READ_STROBE_N_OE | O_WRITE_STROBE_N_OE | O_UPPER_BYTE_ENABLE_N_OE))
        else $error("strobe driven in hold");
    a_ale_tri_unused: assert property (
        (I_SPLIT_BUS_STRAP || I_PERIPHERAL_CONFIG_FIELD != 3'h4) |-> !O_ADDR_LATCH_STROBE_OE)
        else $error("latch strobe driven while unused");
    a_hold_status_low: assert property (
        (I_ARBITER_MASTER_ENABLE && O_IN_HOLD) [*2] |-> O_HOLD_STATUS_PIN_OE && !O_HOLD_STATUS_PIN)
        else $error("hold not confirmed on status pin");
    a_no_new_cycle: assert property (O_IN_HOLD |-> !O_REQ_READY) else $error("request taken in hold");
    // Wait seen during a read keeps the strobe low one more cycle at least
    a_wait_extends: assert property (rd_act && wait_act |=> !O_READ_STROBE_N) else $error("wait ignored");
    a_select_in_access: assert property (
        rd_act |-> !O_PERIPHERAL_SELECT_OUT_N) else $error("read without peripheral select");
    a_serial_pins_mux: assert property (
        !I_SPLIT_BUS_STRAP && I_PERIPHERAL_CONFIG_FIELD == 3'h3 |-> O_LA[6:0] == I_SSC_OUT
        && O_LA_OE[6:0] == I_SSC_OE && O_LA[15:8] == I_GP_OUT) else $error("serial pin mux wrong");
    a_gp_upper_mux: assert property (
        !I_SPLIT_BUS_STRAP && I_PERIPHERAL_CONFIG_FIELD == 3'h2 |-> O_LA[15:8] == I_GP_OUT
        && O_LA_OE[15:8] == I_GP_OE) else $error("general port pins wrong");
    a_req_regained: assert property ($fell(O_IN_HOLD) |-> ##[0:3] O_BUS_REQUEST_OUT)
        else $error("bus request stays low");
    a_ext_arb_keeps: assert property (
        O_IN_HOLD && !I_ARBITER_MASTER_ENABLE && I_HOLD_STATUS_PIN |=> O_IN_HOLD) else $error("left hold early");
    // Main scenarios reached
    c_done: cover property (O_DONE);
    c_wait: cover property (rd_act && wait_act);
    c_ext_hold: cover property (O_IN_HOLD && !I_ARBITER_MASTER_ENABLE);
endmodule
bind lbpm_top lbpm_monitor MON (.*);

// *** lbpm_top_tb.sv ***
// Self-checking bench for the local bus pin mux and hold block
`timescale 1ns/1ps
module lbpm_top_tb;
    // Design ports and bench state
    logic I_MCLK = 0, I_RST = 1, I_SPLIT_BUS_STRAP = 0, I_ARBITER_MASTER_ENABLE = 1, I_READY_ACTIVE_HIGH = 1;
    logic I_REQ = 0, I_REQ_WRITE = 0, I_REQ_UPPER = 0, I_HOLD_REQUEST_IN = 1, hs_ext = 0;
    logic [2:0] I_PERIPHERAL_CONFIG_FIELD = 0;
    logic [1:0] I_CLOCK_DIVIDE_FIELD = 0;
    logic [31:0] I_REQ_ADDR = 0;
    logic [15:0] I_REQ_WDATA = 0, I_LA, I_LD, O_LA, O_LA_OE, O_LD, O_LD_OE, O_RDATA, pd, sla, sld, ald;
    logic [7:0] I_GP_OUT = 0, I_GP_OE = 0, O_GP_IN;
    logic [6:0] I_SSC_OUT = 0, I_SSC_OE = 0, O_SSC_IN;
    logic [3:0] waits = 0;
    logic O_REQ_READY, O_DONE, O_BUS_REQUEST_OUT, I_HOLD_STATUS_PIN, O_HOLD_STATUS_PIN, O_HOLD_STATUS_PIN_OE;
    logic O_IN_HOLD, I_WAIT_READY_IN, O_PERIPHERAL_SELECT_OUT_N, O_ADDR_LATCH_STROBE, O_ADDR_LATCH_STROBE_OE;
    logic O_READ_STROBE_N, O_READ_STROBE_N_OE, O_WRITE_STROBE_N, O_WRITE_STROBE_N_OE, O_LOCAL_BUS_CLOCK;
    logic O_UPPER_BYTE_ENABLE_N, O_UPPER_BYTE_ENABLE_N_OE;
    int mismatches = 0, checks = 0, n, sl, lc = 0;
    realtime tr, hw;
    // Undriven address pins sit at their pull-up level, undriven data pins take the peripheral data
    assign I_LA = O_LA | ~O_LA_OE;
    assign I_LD = (O_LD & O_LD_OE) | (pd & ~O_LD_OE);
    // Status pin is driven by the design as master, else by the arbiter
    assign I_HOLD_STATUS_PIN = O_HOLD_STATUS_PIN_OE ? O_HOLD_STATUS_PIN : hs_ext;
    lbpm_top DUT (.*);
    lbpm_peripheral PER (.clk(I_MCLK), .cs_n(O_PERIPHERAL_SELECT_OUT_N), .rd_n(O_READ_STROBE_N | ~O_READ_STROBE_N_OE),
        .wr_n(O_WRITE_STROBE_N | ~O_WRITE_STROBE_N_OE), .addr(O_LA), .wdata(O_LD), .waits(waits), .rdata(pd),
        .wait_req(I_WAIT_READY_IN));
    initial forever #2 I_MCLK = ~I_MCLK;
    // Local clock edges and high-phase width
    always @(posedge O_LOCAL_BUS_CLOCK) begin
        lc++;
        tr = $realtime;
    end
    always @(negedge O_LOCAL_BUS_CLOCK) hw = $realtime - tr;
    // Pin snapshots while a strobe or the address latch is active
    always @(negedge I_MCLK) begin
        if (!O_READ_STROBE_N || !O_WRITE_STROBE_N) {sla, sld} <= {O_LA, O_LD};
        if (O_ADDR_LATCH_STROBE === 1'b1) ald <= O_LD;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access: request held until taken, then bounded wait for done
    task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
        n = 0;
        sl = 0;
        @(negedge I_MCLK) {I_REQ, I_REQ_WRITE, I_REQ_UPPER, I_REQ_ADDR, I_REQ_WDATA} = {1'b1, w, w, a, d};
        while (O_REQ_READY !== 1'b1 && n < 300) begin
            @(negedge I_MCLK) n++;
        end
        @(negedge I_MCLK) I_REQ = 0;
        while (O_DONE !== 1'b1 && n < 600) begin
            @(negedge I_MCLK) n++;
            if (!O_READ_STROBE_N || !O_WRITE_STROBE_N) sl++;
        end
        chk(n < 600, 1);
    endtask
    task automatic t_rw;
        acc(1'b1, 32'h0000_1234, 16'hA55A);
        chk({sla, sld}, {16'h1234, 16'hA55A});
        chk(O_UPPER_BYTE_ENABLE_N, 0);
        waits = 4'h9;
        acc(1'b0, 32'h0000_1234, 16'h0000);
        chk(O_RDATA, 16'hA55A);
        chk(O_UPPER_BYTE_ENABLE_N, 1);
        chk(sl >= 10, 1);
        waits = 4'h0;
    endtask
    task automatic t_mux;
        {I_GP_OUT, I_GP_OE, I_SSC_OUT, I_SSC_OE} = {8'h5C, 8'hFF, 7'h2B, 7'h7F};
        I_PERIPHERAL_CONFIG_FIELD = 3'h3;
        @(negedge I_MCLK) chk({O_LA[15:8], O_LA[6:0], O_LA_OE[6:0]}, {8'h5C, 7'h2B, 7'h7F});
        chk({O_GP_IN, O_SSC_IN}, {8'h5C, 7'h2B});
        I_PERIPHERAL_CONFIG_FIELD = 3'h2;
        acc(1'b1, 32'h0000_00C8, 16'h0F0F);
        chk({O_LA[15:8], sla[7:0]}, {8'h5C, 8'hC8});
        I_PERIPHERAL_CONFIG_FIELD = 3'h4;
        acc(1'b1, 32'h0000_2468, 16'h1357);
        chk({ald, sld}, {16'h2468, 16'h1357});
        I_SPLIT_BUS_STRAP = 1'b1;
        acc(1'b1, 32'hBEEF_1234, 16'h0000);
        chk({sld, sla[15:2]}, {16'hBEEF, 14'h048D});
        I_SPLIT_BUS_STRAP = 1'b0;
        I_PERIPHERAL_CONFIG_FIELD = 3'h0;
    endtask
    task automatic t_hold;
        n = 0;
        @(negedge I_MCLK) I_HOLD_REQUEST_IN = 1'b0;
        while (O_IN_HOLD !== 1'b1 && n < 100) begin
            @(negedge I_MCLK) n++;
        end
        chk({O_HOLD_STATUS_PIN, O_READ_STROBE_N_OE, O_WRITE_STROBE_N_OE}, 3'h0);
        {I_REQ, I_REQ_WRITE} = 2'h3;
        repeat (40) @(negedge I_MCLK);
        chk({O_BUS_REQUEST_OUT, O_IN_HOLD, O_REQ_READY}, 3'h2);
        I_HOLD_REQUEST_IN = 1'b1;
        acc(1'b1, 32'h0000_0040, 16'h7E81);
        chk(O_BUS_REQUEST_OUT, 1);
    endtask
    task automatic t_ext;
        n = 0;
        {I_ARBITER_MASTER_ENABLE, hs_ext, I_HOLD_REQUEST_IN} = 3'h2;
        while (O_IN_HOLD !== 1'b1 && n < 100) begin
            @(negedge I_MCLK) n++;
        end
        I_HOLD_REQUEST_IN = 1'b1;
        repeat (30) @(negedge I_MCLK);
        chk({O_IN_HOLD, O_HOLD_STATUS_PIN_OE}, 2'h2);
        hs_ext = 1'b0;
        acc(1'b0, 32'h0000_0040, 16'h0000);
        chk(O_RDATA, 16'h7E81);
        I_ARBITER_MASTER_ENABLE = 1'b1;
    endtask
    task automatic t_clk;
        for (int c = 0; c < 4; c++) begin
            I_CLOCK_DIVIDE_FIELD = c[1:0];
            repeat (40) @(posedge I_MCLK);
            n = lc;
            repeat (64) @(posedge I_MCLK);
            chk(lc - n, 64 >> (c + 1));
            chk(hw == 2.0, 1);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge I_MCLK);
        I_RST = 0;
        @(negedge I_MCLK) chk({O_BUS_REQUEST_OUT, O_READ_STROBE_N, O_READ_STROBE_N_OE}, 3'h7);
        t_rw;
        t_mux;
        t_hold;
        t_ext;
        t_clk;
        give_verdict;
    end
    // Watchdog at 25000 clock cycles, well beyond the expected few hundred cycles
    initial begin
        #100000;
        mismatches++;
        give_verdict;
    end
endmodule
